//--- lcdce_pkg.sv
// Shared constants and carrier types for the LCD command executor
package lcdce_pkg;
    localparam int RAM_DEPTH = 40;
    localparam int CONT_BIT = 7;
    // Drive mode field codes
    localparam logic [1:0] DM_STATIC = 2'h1;
    localparam logic [1:0] DM_MUX2 = 2'h2;
    localparam logic [1:0] DM_MUX3 = 2'h3;
    localparam logic [1:0] DM_MUX4 = 2'h0;
    // Fixed opcode patterns, compared against the bits below the continuation bit
    localparam logic [1:0] MODE_PAT = 2'h2;
    localparam logic [3:0] SUBA_PAT = 4'hC;
    localparam logic [4:0] BANK_PAT = 5'h1E;
    localparam logic [3:0] BLINK_PAT = 4'hE;
    // Mode-set field positions
    localparam int MS_LP_BIT = 4;
    localparam int MS_EN_BIT = 3;
    localparam int MS_BIAS_BIT = 2;
    // Bank and blink command field positions
    localparam int BK_IN_BIT = 1;
    localparam int BK_OUT_BIT = 0;
    localparam int BL_AB_BIT = 2;
    // Backplane enables per drive mode
    localparam logic [3:0] BP_EN_STATIC = 4'h1;
    localparam logic [3:0] BP_EN_MUX2 = 4'h3;
    localparam logic [3:0] BP_EN_MUX3 = 4'h7;
    localparam logic [3:0] BP_EN_MUX4 = 4'hF;
    // Pointer advance per display byte in each drive mode
    localparam logic [6:0] STEP_STATIC = 7'h08;
    localparam logic [6:0] STEP_MUX2 = 7'h04;
    localparam logic [6:0] STEP_MUX3 = 7'h03;
    localparam logic [6:0] STEP_MUX4 = 7'h02;
    // Reset values
    localparam logic [1:0] RST_DRIVE_MODE = DM_MUX4;
    localparam logic [5:0] RST_PTR = 6'h00;
    localparam logic [2:0] RST_SUBADDR = 3'h0;

    typedef struct packed {
        logic start;
        logic valid;
        logic [7:0] data;
    } lcdce_byte_t;

    typedef struct packed {
        logic power_saving_flag;
        logic disp_en;
        logic bias_half;
        logic [1:0] drive_mode;
        logic [3:0] bp_en;
        logic in_bank;
        logic out_bank;
        logic alt_bank_blink_flag;
        logic [1:0] blink_rate_field;
    } lcdce_status_t;
endpackage : lcdce_pkg

//--- lcdce_cmd_exec.sv
// Command decoder, status registers and display RAM loader of the LCD driver
//
// Operation
// - Top bit set: next byte is a command; clear: remaining bytes are display data.
// - Pattern 10 in bits 6:5 sets power saving, enable, bias, drive mode.
// - Display blanked while enable is zero, driven while it is one.
// - Bias zero gives one-third, one gives one-half; ignored in static mode.
// - Drive mode codes: 01 static, 10 two-way, 11 three-way, 00 four-way.
// - Backplanes driven: one static, two, three or four in multiplex modes.
// - Bit 6 zero loads bits 5:0 into the data pointer.
// - Pattern 1100 loads the low three bits into the subaddress counter.
// - Bank command bit 1 picks the RAM bank that stores incoming data.
// - Bank command bit 0 picks the RAM bank read out to the display.
// - Bank command ignored in three-way and four-way multiplex.
// - Pattern 1110 sets alternate-bank blink flag and blink rate field.
// - Blink flag zero: normal blinking; one: alternate between RAM banks.
// - Three-way and four-way multiplex force normal blinking.
// - Each decoded command updates the status registers it names, except a bank command in three-way or four-way multiplex.
// - Display bytes fill the RAM in the order the drive mode needs.
// - Pointer advances automatically per display byte; subaddress counter steps when the pointer wraps.
// - Data bytes acknowledged only on subaddress match; commands always acknowledged.
`timescale 1ns/100ps
`default_nettype none
module lcdce_cmd_exec
    import lcdce_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire lcdce_byte_t rx_byte,
    input wire logic [2:0] hw_subaddr,
    input wire logic [5:0] rd_addr,
    output lcdce_status_t status_q,
    output logic ack_q,
    output logic [5:0] ptr_q,
    output logic [2:0] subaddr_q,
    output logic [3:0] seg_data_q
);
    typedef enum {PH_CMD, PH_DATA} lcdce_phase_t;

    lcdce_phase_t phase_q;
    logic [3:0] ram_q [RAM_DEPTH];
    logic [2:0] sa_s1_q, sa_s2_q, sa_s3_q, sa_q;
    logic [7:0] b;
    logic is_cmd, is_data, dec_mode, dec_ptr, dec_suba, dec_bank, dec_blink;
    logic multi_bank, sa_match;
    logic pwr_save_q, disp_en_q, bias_half_q, in_bank_q, out_bank_q, alt_blink_q;
    logic [1:0] drive_mode_q, blink_rate_q;
    logic [3:0] bp_en_q;
    logic [6:0] step, ptr_sum;
    logic [6:0] wr_addr [8];
    logic [1:0] wr_pos [8];

    assign b = rx_byte.data;
    assign is_cmd = rx_byte.valid && !rx_byte.start && phase_q == PH_CMD;
    assign is_data = rx_byte.valid && !rx_byte.start && phase_q == PH_DATA;
    // Opcode decode; anything else in the command phase falls through
    assign dec_mode = is_cmd && b[6:5] == MODE_PAT;
    assign dec_ptr = is_cmd && !b[6];
    assign dec_suba = is_cmd && b[6:3] == SUBA_PAT;
    assign dec_bank = is_cmd && b[6:2] == BANK_PAT;
    assign dec_blink = is_cmd && b[6:3] == BLINK_PAT;
    // Only static and two-way multiplex have a spare RAM bank
    assign multi_bank = status_q.drive_mode == DM_STATIC || status_q.drive_mode == DM_MUX2;
    assign sa_match = sa_q == subaddr_q;
    // Status word is a plain gather of the setting flops, one driver per field
    assign status_q = '{power_saving_flag: pwr_save_q, disp_en: disp_en_q,
        bias_half: bias_half_q, drive_mode: drive_mode_q, bp_en: bp_en_q, in_bank: in_bank_q,
        out_bank: out_bank_q, alt_bank_blink_flag: alt_blink_q, blink_rate_field: blink_rate_q};

    // Subaddress straps pass three flops; accept only when the last two agree
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            sa_s1_q <= 3'h0;
            sa_s2_q <= 3'h0;
            sa_s3_q <= 3'h0;
            sa_q <= 3'h0;
        end
        else
        begin
            sa_s1_q <= hw_subaddr;
            sa_s2_q <= sa_s1_q;
            sa_s3_q <= sa_s2_q;
            if (sa_s2_q == sa_s3_q)
                sa_q <= sa_s3_q;
        end
    end

    // Transfer phase; a new transfer always opens with commands
    // continuation bit
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            phase_q <= PH_CMD;
        else if (rx_byte.valid && rx_byte.start)
            phase_q <= PH_CMD;
        else if (is_cmd && !b[CONT_BIT])
            phase_q <= PH_DATA;
    end

    // Mode-set and blink settings
    // mode-set fields
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            pwr_save_q <= 1'b0;
            disp_en_q <= 1'b0;
            drive_mode_q <= RST_DRIVE_MODE;
            blink_rate_q <= 2'h0;
        end
        else
        begin
            if (dec_mode)
            begin
                pwr_save_q <= b[MS_LP_BIT];
                disp_en_q <= b[MS_EN_BIT];
                drive_mode_q <= b[1:0];
            end
            if (dec_blink)
                blink_rate_q <= b[1:0];
        end
    end

    // Derived settings follow the command so they change with drive mode
    // bias ignored in static
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            bias_half_q <= 1'b0;
            alt_blink_q <= 1'b0;
        end
        else
        begin
            if (dec_mode)
            begin
                bias_half_q <= b[MS_BIAS_BIT] && b[1:0] != DM_STATIC;
                if (b[1:0] == DM_MUX3 || b[1:0] == DM_MUX4)
                    alt_blink_q <= 1'b0;
            end
            if (dec_blink)
                alt_blink_q <= b[BL_AB_BIT] && multi_bank;
        end
    end

    // Backplane enables
    // drive mode decode
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            bp_en_q <= BP_EN_MUX4;
        else if (dec_mode)
        begin
            case (b[1:0])
                DM_STATIC: bp_en_q <= BP_EN_STATIC;
                DM_MUX2: bp_en_q <= BP_EN_MUX2;
                DM_MUX3: bp_en_q <= BP_EN_MUX3;
                default: bp_en_q <= BP_EN_MUX4;
            endcase
        end
    end

    // Bank selects; stale in multiplex modes, so they are held, not cleared
    // input bank
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            in_bank_q <= 1'b0;
            out_bank_q <= 1'b0;
        end
        else if (dec_bank && multi_bank)
        begin
            in_bank_q <= b[BK_IN_BIT];
            out_bank_q <= b[BK_OUT_BIT];
        end
    end

    // Pointer advance per byte depends on bits per RAM word
    assign step = drive_mode_q == DM_STATIC ? STEP_STATIC : drive_mode_q == DM_MUX2 ? STEP_MUX2
        : drive_mode_q == DM_MUX3 ? STEP_MUX3 : STEP_MUX4;
    assign ptr_sum = {1'b0, ptr_q} + step;

    // Pointer and subaddress counter; every device tracks, match or not
    // pointer load
    always_ff @(posedge clk_sys)
    begin
        if (srst)
        begin
            ptr_q <= RST_PTR;
            subaddr_q <= RST_SUBADDR;
        end
        else if (dec_ptr)
            ptr_q <= b[5:0];
        else if (dec_suba)
            subaddr_q <= b[2:0];
        else if (is_data)
        begin
            if (ptr_sum >= 7'(RAM_DEPTH))
            begin
                ptr_q <= RST_PTR;
                subaddr_q <= subaddr_q + 3'h1;
            end
            else
                ptr_q <= ptr_sum[5:0];
        end
    end

    // Filling order: MSB first, one bit per segment, bank offset where it applies
    // filling order
    for (genvar g = 0; g < 8; g++)
    begin : g_fill
        assign wr_addr[g] = {1'b0, ptr_q} + (drive_mode_q == DM_STATIC ? 7'(g)
            : drive_mode_q == DM_MUX2 ? 7'(g / 2)
            : drive_mode_q == DM_MUX3 ? 7'(g / 3) : 7'(g / 4));
        assign wr_pos[g] = drive_mode_q == DM_STATIC ? {in_bank_q, 1'b0}
            : drive_mode_q == DM_MUX2 ? {in_bank_q, 1'(g % 2)}
            : drive_mode_q == DM_MUX3 ? 2'(g % 3) : 2'(g % 4);
    end

    // Display RAM write; bits falling past the last word are dropped
    // subaddress match
    always_ff @(posedge clk_sys)
    begin
        if (is_data && sa_match)
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (wr_addr[i] < 7'(RAM_DEPTH))
                    ram_q[wr_addr[i][5:0]][wr_pos[i]] <= b[7 - i];
            end
        end
    end

    // Acknowledge pulse one cycle after each accepted byte
    // acknowledge select
    always_ff @(posedge clk_sys)
    begin
        if (srst)
            ack_q <= 1'b0;
        else
            ack_q <= is_cmd || (is_data && sa_match);
    end

    // Segment readout with blanking and output bank shift
    // display blanking
    always_ff @(posedge clk_sys)
    begin
        if (srst || !status_q.disp_en || rd_addr >= 6'(RAM_DEPTH))
            seg_data_q <= 4'h0;
        else if (multi_bank && status_q.out_bank)
            seg_data_q <= {2'h0, ram_q[rd_addr][3:2]};
        else
            seg_data_q <= ram_q[rd_addr];
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    phase_cont_a: assert property (is_cmd && !b[CONT_BIT] |=> phase_q == PH_DATA)
        else $error("last command did not enter data phase");
    mode_set_a: assert property (dec_mode |=> status_q.drive_mode == $past(b[1:0])
        && status_q.disp_en == $past(b[MS_EN_BIT]))
        else $error("mode-set fields not taken");
    bias_static_a: assert property (status_q.drive_mode == DM_STATIC |-> !status_q.bias_half)
        else $error("bias active in static mode");
    bp_count_a: assert property (dec_mode && b[1:0] == DM_MUX3 |=> status_q.bp_en == 4'h7)
        else $error("three-way backplanes wrong");
    ptr_load_a: assert property (dec_ptr |=> ptr_q == $past(b[5:0]))
        else $error("pointer load failed");
    suba_load_a: assert property (dec_suba |=> subaddr_q == $past(b[2:0]))
        else $error("subaddress load failed");
    bank_ignore_a: assert property (dec_bank && !multi_bank |=> $stable(status_q.in_bank)
        && $stable(status_q.out_bank))
        else $error("bank changed in multiplex mode");
    alt_blink_a: assert property (!multi_bank |-> !status_q.alt_bank_blink_flag)
        else $error("alternate blink in multiplex mode");
    ack_data_a: assert property (is_data && !sa_match |=> !ack_q)
        else $error("data acknowledged without match");
    blank_out_a: assert property (!status_q.disp_en |=> seg_data_q == 4'h0)
        else $error("segments driven while disabled");
endmodule : lcdce_cmd_exec
`default_nettype wire

//--- lcdce_host_model.sv
// Behavioural bus master that hands command and display bytes to the executor
`timescale 1ns/100ps
`default_nettype none
module lcdce_host_model
    import lcdce_pkg::*;
(
    input wire logic clk_sys,
    output lcdce_byte_t rx_byte
);

    // Idle byte lane shows the inverse of the last byte, never a stale copy
    initial
    begin
        rx_byte = '{start: 1'b0, valid: 1'b0, data: 8'hFF};
    end

    // Start pulse and byte
    // Returns at the edge that takes the byte, after one valid cycle
    task automatic send(input logic st, input logic [7:0] d);
        @(posedge clk_sys);
        rx_byte <= '{start: st, valid: 1'b1, data: d};
        @(posedge clk_sys);
        rx_byte <= '{start: 1'b0, valid: 1'b0, data: ~d};
    endtask : send
endmodule : lcdce_host_model
`default_nettype wire

//--- lcdce_cmd_exec_bench.sv
// Self-checking bench for the LCD command executor
`timescale 1ns/100ps
`default_nettype none
module lcdce_cmd_exec_bench;
    import lcdce_pkg::*;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    lcdce_byte_t rx_byte;
    logic [2:0] hw_subaddr = 3'h0;
    logic [5:0] rd_addr = 6'h00;
    lcdce_status_t status_q;
    lcdce_status_t keep;
    logic ack_q;
    logic [5:0] ptr_q;
    logic [2:0] subaddr_q;
    logic [3:0] seg_data_q;
    int err_count = 0;
    int num_checks = 0;
    int cyc = 0;

    lcdce_host_model u_host (.clk_sys(clk_sys), .rx_byte(rx_byte));
    lcdce_cmd_exec u_dut (.clk_sys(clk_sys), .srst(srst), .rx_byte(rx_byte),
        .hw_subaddr(hw_subaddr), .rd_addr(rd_addr), .status_q(status_q), .ack_q(ack_q),
        .ptr_q(ptr_q), .subaddr_q(subaddr_q), .seg_data_q(seg_data_q));

    // Clock and hang guard; a whole run needs well under a thousand cycles
    always #10 clk_sys = ~clk_sys;
    always @(posedge clk_sys)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            results();
        end
    end

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Command byte, then its acknowledge in the cycle after the taking edge
    task automatic cmd(input logic [7:0] d);
        u_host.send(1'b0, d);
        #1;
        chk("ack", 8'h01, {7'h00, ack_q});
    endtask : cmd

    task automatic t_modes();
        logic [1:0] m;
        logic [3:0] bp;
        for (int i = 0; i < 4; i++)
        begin
            m = i[1:0];
            bp = (m == DM_STATIC) ? 4'h1 : (m == DM_MUX2) ? 4'h3 : (m == DM_MUX3) ? 4'h7 : 4'hF;
            cmd({3'h6, i[0], 2'h3, m});
            chk("lp", {7'h00, i[0]}, {7'h00, status_q.power_saving_flag});
            chk("mode", {6'h00, m}, {6'h00, status_q.drive_mode});
            chk("bp", {4'h0, bp}, {4'h0, status_q.bp_en});
            chk("bias", {7'h00, m != DM_STATIC}, {7'h00, status_q.bias_half});
            chk("en", 8'h01, {7'h00, status_q.disp_en});
        end
    endtask : t_modes

    task automatic t_ptr_sub();
        cmd(8'hA7);
        chk("ptr", 8'h27, {2'h0, ptr_q});
        cmd(8'h80);
        chk("ptr", 8'h00, {2'h0, ptr_q});
        for (int a = 7; a >= 0; a--)
        begin
            cmd(8'hE0 | a[7:0]);
            chk("subaddr", a[7:0], {5'h00, subaddr_q});
        end
    endtask : t_ptr_sub

    task automatic t_bank_blink();
        cmd(8'hC9);
        cmd(8'hFB);
        chk("banks", 8'h03, {6'h00, status_q.in_bank, status_q.out_bank});
        cmd(8'hFA);
        chk("banks", 8'h02, {6'h00, status_q.in_bank, status_q.out_bank});
        cmd(8'hC8);
        cmd(8'hF9);
        chk("banks", 8'h02, {6'h00, status_q.in_bank, status_q.out_bank});
        cmd(8'hCA);
        for (int r = 0; r < 4; r++)
        begin
            cmd(8'hF4 | r[7:0]);
            chk("blink", 8'h04 | r[7:0], {5'h00, status_q.alt_bank_blink_flag,
                status_q.blink_rate_field});
        end
        cmd(8'hCB);
        cmd(8'hF7);
        chk("blink", 8'h03, {5'h00, status_q.alt_bank_blink_flag,
            status_q.blink_rate_field});
        keep = status_q;
        cmd(8'hFF);
        chk("keep", 8'h01, {7'h00, status_q === keep});
    endtask : t_bank_blink

    task automatic rd(input logic [5:0] a, input logic [3:0] exp);
        @(posedge clk_sys);
        rd_addr <= a;
        @(posedge clk_sys);
        #1;
        chk("seg", {4'h0, exp}, {4'h0, seg_data_q});
    endtask : rd

    task automatic t_data();
        cmd(8'hC8);
        cmd(8'h26);
        u_host.send(1'b0, 8'hA5);
        #1;
        chk("ack", 8'h01, {7'h00, ack_q});
        chk("ptr", 8'h00, {2'h0, ptr_q});
        chk("subaddr", 8'h01, {5'h00, subaddr_q});
        // Counter no longer matches the straps: no acknowledge, pointer still moves
        u_host.send(1'b0, 8'h3C);
        #1;
        chk("ack", 8'h00, {7'h00, ack_q});
        chk("ptr", 8'h02, {2'h0, ptr_q});
        rd(6'h26, 4'h5);
        rd(6'h27, 4'hA);
        // Straps moved to 1; the synchroniser accepts them four edges later
        @(posedge clk_sys);
        hw_subaddr <= 3'h1;
        repeat (4) @(posedge clk_sys);
        u_host.send(1'b0, 8'hF0);
        #1;
        chk("ack", 8'h01, {7'h00, ack_q});
        chk("ptr", 8'h04, {2'h0, ptr_q});
        rd(6'h02, 4'hF);
        // Static mode: store into and show the upper bank
        u_host.send(1'b1, 8'h00);
        cmd(8'hC9);
        cmd(8'hFB);
        cmd(8'h03);
        u_host.send(1'b0, 8'h80);
        rd(6'h03, 4'h1);
        // New transfer whose mode-set clears the enable: display blanks
        u_host.send(1'b1, 8'h00);
        cmd(8'h41);
        rd(6'h03, 4'h0);
    endtask : t_data

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results

    // Main sequence after three reset cycles and strap settling
    initial
    begin
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        repeat (5) @(posedge clk_sys);
        #1;
        chk("mode", 8'h00, {6'h00, status_q.drive_mode});
        chk("bp", 8'h0F, {4'h0, status_q.bp_en});
        chk("en", 8'h00, {7'h00, status_q.disp_en});
        t_modes();
        t_ptr_sub();
        t_bank_blink();
        t_data();
        results();
    end
endmodule : lcdce_cmd_exec_bench
`default_nettype wire
